// ==== rtl/pwt_pin_sync.sv ====
// Two flip-flop synchroniser for a pin sampled on CLK.
`timescale 1ns/1ps
module pwt_pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    pwt_pkg::pwt_sync_t r;
    pwt_pkg::pwt_sync_t nxt;

    always_comb begin
        nxt.s1 = d;
        nxt.s2 = r.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign q = r.s2;
endmodule : pwt_pin_sync

// ==== rtl/pwt_pkg.sv ====
// Types shared by the prescaled one-shot waveform timer.
package pwt_pkg;

    typedef enum logic [1:0] {
        PWT_TIMER = 2'h0,
        PWT_WAVE = 2'h1,
        PWT_ONESHOT = 2'h2,
        PWT_WAIT = 2'h3
    } pwt_mode_t;

    typedef enum logic {
        PWT_PH_PRI = 1'b0,
        PWT_PH_SEC = 1'b1
    } pwt_phase_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } pwt_sync_t;

    typedef struct packed {
        logic [6:0] div;
        logic [2:0] src_sel;
        pwt_mode_t mode;
        logic start;
        logic os_tgt;
        logic out_lvl;
        logic trig_en;
        logic port_dir;
        logic port_dat;
        logic [7:0] pre_reg;
        logic [7:0] sec_reg;
        logic [7:0] pri_reg;
        logic [7:0] pre_cnt;
        logic [7:0] tmr_cnt;
        pwt_phase_t phase;
        logic out;
        logic ext_q;
        logic [1:0] ist;
        logic [1:0] ien;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pwt_state_t;

endpackage : pwt_pkg

// ==== rtl/pwt_regs.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef PWT_REGS_SVH
`define PWT_REGS_SVH

`define PWT_CTRL_OFS 8'h00
`define PWT_OSCTRL_OFS 8'h04
`define PWT_IOCTRL_OFS 8'h08
`define PWT_MODE_OFS 8'h0C
`define PWT_PRE_OFS 8'h10
`define PWT_SEC_OFS 8'h14
`define PWT_PRI_OFS 8'h18
`define PWT_PORT_OFS 8'h1C
`define PWT_ISTAT_OFS 8'h20
`define PWT_IEN_OFS 8'h24
`define PWT_ICLR_OFS 8'h28

`define PWT_CTRL_START_BIT 0
`define PWT_CTRL_STATUS_BIT 1
`define PWT_CTRL_STOP_BIT 2
`define PWT_OS_START_BIT 0
`define PWT_OS_STOP_BIT 1
`define PWT_OS_STATUS_BIT 2
`define PWT_IO_LEVEL_BIT 0
`define PWT_IO_TRIG_BIT 1
`define PWT_PORT_DIR_BIT 0
`define PWT_PORT_DATA_BIT 1
`define PWT_MODE_LSB 0
`define PWT_SRC_LSB 4
`define PWT_INT_UF_BIT 0
`define PWT_INT_OS_BIT 1

`define PWT_PRE_RST 8'hFF
`define PWT_SEC_RST 8'hFF
`define PWT_PRI_RST 8'hFF

// Count source tick: CLK divided by 2**select, select 0..7.
`define PWT_DIV_W 7
`define PWT_SYNC_STAGES 2

`endif

// ==== rtl/pwt_tick_sync.sv ====
// Two-stage synchroniser that advances only on count source ticks.
`timescale 1ns/1ps
module pwt_tick_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic clr,
    input wire logic d,
    output logic q
);
    pwt_pkg::pwt_sync_t r;
    pwt_pkg::pwt_sync_t nxt;

    // Clear empties both stages at once, so a forced halt never waits.
    always_comb begin
        nxt = r;
        if (clr) begin
            nxt = '0;
        end else if (tick) begin
            nxt.s1 = d;
            nxt.s2 = r.s1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign q = r.s2;
endmodule : pwt_tick_sync

// ==== rtl/pwt_timer.sv ====
// Prescaled 8-bit down-counting timer with waveform and one-shot modes.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "pwt_regs.svh"

module pwt_timer (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic EXT_TRIG,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    output logic TIMER_OUT
);
    pwt_pkg::pwt_state_t r;
    pwt_pkg::pwt_state_t s;

    logic [6:0] mask;
    logic tick;
    logic cs;
    logic os_st;
    logic ext_s;
    logic setup;
    logic wr;
    logic stop_now;
    logic os_done;
    logic os_clr;
    logic oneshot_mode;
    logic active;
    logic idle_lvl;
    logic wave_mode;
    logic trig_edge;
    logic [1:0] ev;
    logic [31:0] rdata;

    function automatic logic pwt_hit(input logic [7:0] a);
        pwt_hit = (a == `PWT_CTRL_OFS) || (a == `PWT_OSCTRL_OFS) ||
            (a == `PWT_IOCTRL_OFS) || (a == `PWT_MODE_OFS) ||
            (a == `PWT_PRE_OFS) || (a == `PWT_SEC_OFS) ||
            (a == `PWT_PRI_OFS) || (a == `PWT_PORT_OFS) ||
            (a == `PWT_ISTAT_OFS) || (a == `PWT_IEN_OFS) ||
            (a == `PWT_ICLR_OFS);
    endfunction : pwt_hit

    // The count source is a tick enable derived from CLK by a power of two.
    assign mask = 7'((8'h01 << r.src_sel) - 8'h01);
    assign tick = ((r.div & mask) == mask);

    // Ready is registered from the first access cycle: one wait state.
    assign setup = PSEL & PENABLE & ~r.pready;
    assign wr = PSEL & PENABLE & r.pready & PWRITE;
    assign stop_now = wr & (PADDR == `PWT_CTRL_OFS) &
        PWDATA[`PWT_CTRL_STOP_BIT];
    assign oneshot_mode = (r.mode == pwt_pkg::PWT_ONESHOT) ||
        (r.mode == pwt_pkg::PWT_WAIT);
    assign idle_lvl = ~r.out_lvl;
    assign wave_mode = (r.mode == pwt_pkg::PWT_WAVE);
    assign trig_edge = ext_s & ~r.ext_q;
    assign os_clr = stop_now | os_done;

    // Status is the second stage, so it trails start by two ticks.
    pwt_tick_sync u_start_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .tick(tick),
        .clr(stop_now),
        .d(r.start),
        .q(cs)
    );

    pwt_tick_sync u_os_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .tick(tick),
        .clr(os_clr),
        .d(r.os_tgt),
        .q(os_st)
    );

    // The pin is asynchronous to CLK, so two flops come before any logic.
    pwt_pin_sync u_trig_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .d(EXT_TRIG),
        .q(ext_s)
    );

    // One-shot modes only run while the one-shot status is also set.
    assign active = cs & ~stop_now & (~oneshot_mode | os_st);

    // Read data is picked in the first access cycle and registered.
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (PADDR)
            `PWT_CTRL_OFS: begin
                rdata[`PWT_CTRL_START_BIT] = r.start;
                rdata[`PWT_CTRL_STATUS_BIT] = cs;
            end
            `PWT_OSCTRL_OFS: begin
                rdata[`PWT_OS_STATUS_BIT] = os_st;
            end
            `PWT_IOCTRL_OFS: begin
                rdata[`PWT_IO_LEVEL_BIT] = r.out_lvl;
                rdata[`PWT_IO_TRIG_BIT] = r.trig_en;
            end
            `PWT_MODE_OFS: begin
                rdata[`PWT_MODE_LSB +: 2] = r.mode;
                rdata[`PWT_SRC_LSB +: 3] = r.src_sel;
            end
            // Each half reads live; a count may land between the two reads.
            `PWT_PRE_OFS: begin
                rdata[7:0] = r.pre_cnt;
            end
            `PWT_SEC_OFS: begin
                rdata[7:0] = r.sec_reg;
            end
            `PWT_PRI_OFS: begin
                rdata[7:0] = r.tmr_cnt;
            end
            `PWT_PORT_OFS: begin
                rdata[`PWT_PORT_DIR_BIT] = r.port_dir;
                rdata[`PWT_PORT_DATA_BIT] =
                    r.port_dir ? r.port_dat : r.out;
            end
            `PWT_ISTAT_OFS: begin
                rdata[1:0] = r.ist;
            end
            `PWT_IEN_OFS: begin
                rdata[1:0] = r.ien;
            end
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_comb begin
        s = r;
        ev = 2'h0;
        os_done = 1'b0;
        s.div = r.div + 7'h01;

        s.pready = setup;
        s.pslverr = setup & ~pwt_hit(PADDR);
        s.prdata = (setup & ~PWRITE) ? rdata : 32'h0000_0000;

        // Counting engine, one step per count source tick.
        if (active && tick) begin
            if (r.pre_cnt == 8'h00) begin
                s.pre_cnt = r.pre_reg;
                if (r.tmr_cnt == 8'h00) begin
                    ev[`PWT_INT_UF_BIT] = 1'b1;
                    unique case (r.mode)
                        pwt_pkg::PWT_TIMER: s.tmr_cnt = r.pri_reg;
                        pwt_pkg::PWT_WAVE: begin
                            if (r.phase == pwt_pkg::PWT_PH_PRI) begin
                                s.phase = pwt_pkg::PWT_PH_SEC;
                                s.tmr_cnt = r.sec_reg;
                                s.out = idle_lvl;
                            end else begin
                                s.phase = pwt_pkg::PWT_PH_PRI;
                                s.tmr_cnt = r.pri_reg;
                                s.out = r.out_lvl;
                            end
                        end
                        pwt_pkg::PWT_ONESHOT: begin
                            os_done = 1'b1;
                            s.tmr_cnt = r.pri_reg;
                            s.out = idle_lvl;
                        end
                        pwt_pkg::PWT_WAIT: begin
                            if (r.phase == pwt_pkg::PWT_PH_SEC) begin
                                s.phase = pwt_pkg::PWT_PH_PRI;
                                s.tmr_cnt = r.pri_reg;
                                s.out = r.out_lvl;
                            end else begin
                                os_done = 1'b1;
                                s.phase = pwt_pkg::PWT_PH_SEC;
                                s.tmr_cnt = r.sec_reg;
                                s.out = idle_lvl;
                            end
                        end
                    endcase
                end else begin
                    s.tmr_cnt = r.tmr_cnt - 8'h01;
                end
            end else begin
                s.pre_cnt = r.pre_cnt - 8'h01;
            end
            if (r.mode == pwt_pkg::PWT_ONESHOT && !os_done) begin
                s.out = r.out_lvl;
            end
        end else if (oneshot_mode && !active) begin
            // A stopped one-shot always sits at its reload values.
            s.pre_cnt = r.pre_reg;
            if (r.mode == pwt_pkg::PWT_WAIT) begin
                s.tmr_cnt = r.sec_reg;
                s.phase = pwt_pkg::PWT_PH_SEC;
            end else begin
                s.tmr_cnt = r.pri_reg;
                s.phase = pwt_pkg::PWT_PH_PRI;
            end
            s.out = idle_lvl;
        end

        // The waveform pin follows the phase from the first tick on,
        // not only from the first phase change.
        if (active && wave_mode) begin
            if (s.phase == pwt_pkg::PWT_PH_PRI) begin
                s.out = r.out_lvl;
            end else begin
                s.out = idle_lvl;
            end
        end

        if (os_done) begin
            ev[`PWT_INT_OS_BIT] = 1'b1;
            s.os_tgt = 1'b0;
        end

        // Trigger pin edge arms a one-shot like a start write would.
        s.ext_q = ext_s;
        if (trig_edge && r.trig_en && cs && oneshot_mode) begin
            s.os_tgt = 1'b1;
        end

        if (wr) begin
            unique case (PADDR)
                `PWT_CTRL_OFS: begin
                    s.start = PWDATA[`PWT_CTRL_START_BIT] &
                        ~PWDATA[`PWT_CTRL_STOP_BIT];
                end
                `PWT_OSCTRL_OFS: begin
                    // Stop wins when both are written together.
                    if (PWDATA[`PWT_OS_STOP_BIT]) begin
                        s.os_tgt = 1'b0;
                    end else if (PWDATA[`PWT_OS_START_BIT]) begin
                        s.os_tgt = 1'b1;
                    end
                end
                `PWT_IOCTRL_OFS: begin
                    s.out_lvl = PWDATA[`PWT_IO_LEVEL_BIT];
                    s.trig_en = PWDATA[`PWT_IO_TRIG_BIT];
                end
                `PWT_MODE_OFS: begin
                    s.mode = pwt_pkg::pwt_mode_t'(PWDATA[`PWT_MODE_LSB +: 2]);
                    s.src_sel = PWDATA[`PWT_SRC_LSB +: 3];
                end
                `PWT_PRE_OFS: begin
                    s.pre_reg = PWDATA[7:0];
                    if (!cs) begin
                        s.pre_cnt = PWDATA[7:0];
                    end
                end
                `PWT_SEC_OFS: begin
                    s.sec_reg = PWDATA[7:0];
                end
                `PWT_PRI_OFS: begin
                    s.pri_reg = PWDATA[7:0];
                    if (!cs) begin
                        s.tmr_cnt = PWDATA[7:0];
                    end
                end
                `PWT_PORT_OFS: begin
                    s.port_dir = PWDATA[`PWT_PORT_DIR_BIT];
                    s.port_dat = PWDATA[`PWT_PORT_DATA_BIT];
                end
                `PWT_IEN_OFS: begin
                    s.ien = PWDATA[1:0];
                end
                `PWT_ISTAT_OFS: begin
                    // Status is read-only; a write leaves it alone.
                    s.ist = r.ist;
                end
                `PWT_ICLR_OFS: begin
                    // The clear is merged with new events further down.
                    s.ist = r.ist;
                end
                default: s.start = s.start;
            endcase
        end

        // Waveform halt during the primary phase restores the prescaler and primary reset periods; the secondary reload keeps its value.
        if (stop_now && wave_mode &&
            r.phase == pwt_pkg::PWT_PH_PRI && cs) begin
            s.pre_reg = `PWT_PRE_RST;
            s.pri_reg = `PWT_PRI_RST;
            s.pre_cnt = `PWT_PRE_RST;
            s.tmr_cnt = `PWT_PRI_RST;
        end

        // A new event outranks a clear written in the same cycle.
        if (wr && PADDR == `PWT_ICLR_OFS) begin
            s.ist = (r.ist & ~PWDATA[1:0]) | ev;
        end else begin
            s.ist = r.ist | ev;
        end
        s.irq = |(s.ist & s.ien);
    end

    // Reset leaves the counter stopped with every reload at its default.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            r <= '0;
            r.mode <= pwt_pkg::PWT_TIMER;
            r.phase <= pwt_pkg::PWT_PH_PRI;
            r.out_lvl <= 1'b1;
            r.pre_reg <= `PWT_PRE_RST;
            r.sec_reg <= `PWT_SEC_RST;
            r.pri_reg <= `PWT_PRI_RST;
            r.pre_cnt <= `PWT_PRE_RST;
            r.tmr_cnt <= `PWT_PRI_RST;
        end else begin
            r <= s;
        end
    end

    assign PRDATA = r.prdata;
    assign PREADY = r.pready;
    assign PSLVERR = r.pslverr;
    assign IRQ = r.irq;
    assign TIMER_OUT = r.out;
endmodule : pwt_timer

// ==== test/pwt_timer_chk.sv ====
// Port-level assertions for the prescaled one-shot waveform timer.
`timescale 1ns/1ps
`include "pwt_regs.svh"
module pwt_timer_chk (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ,
    input wire logic TIMER_OUT
);
    logic dir_r;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Direction is shadowed here because the read-back source depends on it.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dir_r <= 1'b0;
        end else if (PSEL && PENABLE && PREADY && PWRITE
                     && PADDR == `PWT_PORT_OFS) begin
            dir_r <= PWDATA[`PWT_PORT_DIR_BIT];
        end
    end
    a_one_wait: assert property ($rose(PENABLE) && PSEL
        |-> !PREADY ##1 PREADY) else $error("ready not after one wait");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside an access");
    a_err_unmapped: assert property (PREADY && PADDR > `PWT_ICLR_OFS
        |-> PSLVERR) else $error("no error on unmapped address");
    a_err_mapped: assert property (PREADY && PADDR <= `PWT_ICLR_OFS
        && PADDR[1:0] == 2'h0 |-> !PSLVERR)
        else $error("error on mapped address");
    a_rdata_quiet: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside ready");
    a_reset_idle: assert property ($rose(RST_N) |-> !IRQ && !TIMER_OUT
        && !PREADY) else $error("outputs busy after reset");
    a_ien_masks: assert property (PSEL && PENABLE && PREADY && PWRITE
        && PADDR == `PWT_IEN_OFS && PWDATA[1:0] == 2'h0 |-> ##2 !IRQ)
        else $error("interrupt stays high with all disabled");
    a_port_input: assert property (PREADY && !PWRITE && !dir_r
        && PADDR == `PWT_PORT_OFS
        |-> PRDATA[`PWT_PORT_DATA_BIT] == $past(TIMER_OUT))
        else $error("port read does not show output level");
endmodule : pwt_timer_chk

// ==== test/pwt_trig_model.sv ====
// External trigger source driving the one-shot trigger pin.
`timescale 1ns/1ps
module pwt_trig_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fire,
    output logic trig
);
    logic [2:0] cnt;
    // Four clocks high, so the two-flop sampler cannot miss the edge.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
        end else if (fire) begin
            cnt <= 3'h4;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end
    end
    assign trig = (cnt != 3'h0);
endmodule : pwt_trig_model

// ==== test/tb_pwt_timer.sv ====
// Self-checking bench for the prescaled one-shot waveform timer.
`timescale 1ns/1ps
`include "pwt_regs.svh"
module tb_pwt_timer;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic fire = 1'b0;
    logic EXT_TRIG, PREADY, PSLVERR, IRQ, TIMER_OUT, err;
    logic [31:0] PRDATA, rdv;
    int n_errors = 0;
    int check_count = 0;
    logic [7:0] ra [6] = '{`PWT_CTRL_OFS, `PWT_PRE_OFS, `PWT_SEC_OFS,
        `PWT_PRI_OFS, `PWT_IOCTRL_OFS, `PWT_ISTAT_OFS};
    logic [31:0] rv [6] = '{32'h0, {24'h0, `PWT_PRE_RST},
        {24'h0, `PWT_SEC_RST}, {24'h0, `PWT_PRI_RST}, 32'h1, 32'h0};

    always #2.5 CLK = ~CLK;

    pwt_timer u_pwt_timer (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .EXT_TRIG, .PRDATA, .PREADY, .PSLVERR, .IRQ, .TIMER_OUT);
    pwt_trig_model u_pwt_trig_model (.clk(CLK), .rst_n(RST_N),
        .fire(fire), .trig(EXT_TRIG));

    task automatic final_report;
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Ready is sampled at each rising edge while the request still stands.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (PREADY !== 1'b1) begin
            n_errors++;
            final_report();
        end
        rdv = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(nm, rdv, exp);
    endtask : rdc

    task automatic poll(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            xfer(1'b0, a, 32'h0);
            n++;
        end while ((rdv & m) !== v && n < 40);
        chk(nm, rdv & m, v);
    endtask : poll

    task automatic wt_irq;
        int n;
        n = 0;
        while (IRQ !== 1'b1 && n < 400) begin
            @(negedge CLK);
            n++;
        end
        chk("irq", 32'(IRQ), 32'h1);
    endtask : wt_irq

    task automatic pulse;
        @(posedge CLK);
        fire <= 1'b1;
        @(posedge CLK);
        fire <= 1'b0;
    endtask : pulse

    initial begin
        repeat (60000) @(posedge CLK);
        n_errors++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rdc("reset value", ra[i], rv[i]);
        end
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        // Timer mode on a slow tick makes the sync delay visible.
        wr(`PWT_MODE_OFS, 32'h20);
        wr(`PWT_PRE_OFS, 32'h0);
        wr(`PWT_PRI_OFS, 32'h3);
        wr(`PWT_IEN_OFS, 32'h1);
        wr(`PWT_CTRL_OFS, 32'h1);
        rdc("status early", `PWT_CTRL_OFS, 32'h1);
        poll("status on", `PWT_CTRL_OFS, 32'h2, 32'h2);
        wt_irq();
        wr(`PWT_CTRL_OFS, 32'h0);
        rdc("status late", `PWT_CTRL_OFS, 32'h2);
        poll("status off", `PWT_CTRL_OFS, 32'h2, 32'h0);
        wr(`PWT_ICLR_OFS, 32'h1);
        rdc("istat clear", `PWT_ISTAT_OFS, 32'h0);
        chk("irq low", 32'(IRQ), 32'h0);
        wr(`PWT_MODE_OFS, 32'h1);
        wr(`PWT_PRE_OFS, 32'h2);
        wr(`PWT_PRI_OFS, 32'h5);
        wr(`PWT_CTRL_OFS, 32'h1);
        wr(`PWT_CTRL_OFS, 32'h4);
        rdc("forced stop", `PWT_CTRL_OFS, 32'h0);
        rdc("pre reinit", `PWT_PRE_OFS, rv[1]);
        rdc("pri reinit", `PWT_PRI_OFS, rv[3]);
        wr(`PWT_MODE_OFS, 32'h2);
        wr(`PWT_PRE_OFS, 32'h0);
        wr(`PWT_PRI_OFS, 32'h40);
        wr(`PWT_PORT_OFS, 32'h0);
        wr(`PWT_CTRL_OFS, 32'h1);
        poll("status on", `PWT_CTRL_OFS, 32'h2, 32'h2);
        rdc("port idle", `PWT_PORT_OFS, 32'h0);
        chk("out idle", 32'(TIMER_OUT), 32'h0);
        wr(`PWT_OSCTRL_OFS, 32'h1);
        poll("os on", `PWT_OSCTRL_OFS, 32'h4, 32'h4);
        rdc("port run", `PWT_PORT_OFS, 32'h2);
        chk("out run", 32'(TIMER_OUT), 32'h1);
        wr(`PWT_OSCTRL_OFS, 32'h2);
        poll("os off", `PWT_OSCTRL_OFS, 32'h4, 32'h0);
        rdc("reload on stop", `PWT_PRI_OFS, 32'h40);
        wr(`PWT_ICLR_OFS, 32'h3);
        wr(`PWT_IEN_OFS, 32'h2);
        wr(`PWT_OSCTRL_OFS, 32'h1);
        wt_irq();
        poll("os done", `PWT_ISTAT_OFS, 32'h2, 32'h2);
        wr(`PWT_OSCTRL_OFS, 32'h1);
        poll("os on", `PWT_OSCTRL_OFS, 32'h4, 32'h4);
        wr(`PWT_CTRL_OFS, 32'h0);
        poll("status off", `PWT_CTRL_OFS, 32'h2, 32'h0);
        rdc("reload on clear", `PWT_PRI_OFS, 32'h40);
        wr(`PWT_OSCTRL_OFS, 32'h2);
        poll("os idle", `PWT_OSCTRL_OFS, 32'h4, 32'h0);
        wr(`PWT_ICLR_OFS, 32'h3);
        wr(`PWT_MODE_OFS, 32'h3);
        wr(`PWT_IOCTRL_OFS, 32'h3);
        wr(`PWT_SEC_OFS, 32'h20);
        wr(`PWT_PRI_OFS, 32'h20);
        wr(`PWT_CTRL_OFS, 32'h1);
        poll("status on", `PWT_CTRL_OFS, 32'h2, 32'h2);
        pulse();
        poll("trig os", `PWT_OSCTRL_OFS, 32'h4, 32'h4);
        wt_irq();
        wr(`PWT_IEN_OFS, 32'h0);
        @(posedge CLK);
        chk("irq masked", 32'(IRQ), 32'h0);
        wr(`PWT_CTRL_OFS, 32'h0);
        poll("status off", `PWT_CTRL_OFS, 32'h2, 32'h0);
        wr(`PWT_MODE_OFS, 32'h0);
        wr(`PWT_CTRL_OFS, 32'h1);
        poll("status on", `PWT_CTRL_OFS, 32'h2, 32'h2);
        pulse();
        repeat (8) @(posedge CLK);
        rdc("trig ignored", `PWT_OSCTRL_OFS, 32'h0);
        final_report();
    end
endmodule : tb_pwt_timer

bind pwt_timer pwt_timer_chk u_pwt_timer_chk (.CLK, .RST_N, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ,
    .TIMER_OUT);
